// File: logic/ctsa_defines.svh
// Constants for the CAN transmit select, abort acknowledge and acceptance control block.
// Assumes a 32-bit Avalon-MM slave with word addresses given here as byte offsets.
//
// Behaviour
// - Abort-acknowledge register held at reset while init request and acknowledge are both 1.
// - Software writes to the three abort-acknowledge flags are ignored.
// - Abort-acknowledge flag sets when a buffer is aborted on pending abort request.
// - Abort-acknowledge flag clears when software clears that buffer's empty flag.
// - Buffer select held at reset in init mode; writable only when both init bits 0.
// - Buffer select reads back only its lowest set bit; other bits read zero.
// - Lowest set select bit maps that buffer into the shared transmit window.
// - Window access blocked while selected buffer is loaded and scheduled.
// - No buffer selected means no access to the shared transmit window.
// - Acceptance control writable only in init mode; hit field always read-only.
// - Mode field bits 5:4: 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - Filter closed accepts no message; foreground receive buffer never reloaded.
// - Hit field reports binary number 0 to 7 of the matching filter.
// - Hit field follows the foreground buffer, updated on each shift into it.
// - Factory-reserved register reads zero and ignores writes in normal modes.
// - Abort granted only before transmission start or after lost arbitration or error.
// - Empty flag sets after successful send or abort; 1 empty, 0 scheduled.
`ifndef CTSA_DEFINES_SVH
`define CTSA_DEFINES_SVH

// Register byte offsets
`define CTSA_OFS_EMPTY    4'h0
`define CTSA_OFS_ABORT_RQ 4'h1
`define CTSA_OFS_ABORT_AK 4'h2
`define CTSA_OFS_SELECT   4'h3
`define CTSA_OFS_ACC_CTL  4'h4
`define CTSA_OFS_RESERVED 4'h5
`define CTSA_OFS_IRQ_STAT 4'h6
`define CTSA_OFS_IRQ_MASK 4'h7

// Field layout
`define CTSA_NBUF      3
`define CTSA_MODE_HI   5
`define CTSA_MODE_LO   4
`define CTSA_HIT_HI    2
`define CTSA_HIT_LO    0

// Reset values
`define CTSA_RST_EMPTY  3'h7
`define CTSA_RST_ZERO3  3'h0
`define CTSA_RST_MODE   2'h0
`define CTSA_RST_ZERO8  8'h00
`define CTSA_RST_ZERO32 32'h0000_0000

// Status bit positions
`define CTSA_IRQ_ABORT  0
`define CTSA_IRQ_SENT   1
`define CTSA_IRQ_RXHIT  2

`endif

// File: logic/ctsa_pkg.sv
// Types for the CAN transmit select and acceptance control block.
// Assumes ctsa_defines.svh is on the include path.
`include "ctsa_defines.svh"
package ctsa_pkg;

  // Filter organisation
  typedef enum logic [1:0] {
    CTSA_TWO_32,
    CTSA_FOUR_16,
    CTSA_EIGHT_8,
    CTSA_CLOSED
  } ctsa_mode_t;

  // Events from the protocol engine: one bit per transmit buffer, plus the receive shift and hit number
  typedef struct packed {
    logic [2:0] sent_ok;
    logic [2:0] tx_started;
    logic [2:0] tx_failed;
    logic [2:0] abort_slot;
    logic rx_shift;
    logic [2:0] rx_hit;
  } ctsa_engine_t;

  // Shared transmit window request
  typedef struct packed {
    logic req;
    logic write;
    logic [3:0] address;
    logic [7:0] writedata;
  } ctsa_win_req_t;

  typedef struct packed {
    logic grant;
    logic [1:0] buffer;
    logic denied;
  } ctsa_win_ans_t;

endpackage : ctsa_pkg

// File: logic/ctsa_lowest_bit.sv
// Isolates the lowest set bit of a small vector and gives its index.
// Assumes a purely combinational use inside the register block.
module ctsa_lowest_bit #(
  parameter int WIDTH = 3
) (
  // Input vector
  input wire logic [WIDTH-1:0] vec,
  // Results
  output logic [WIDTH-1:0] onehot,
  output logic [1:0] index,
  output logic any
);
  import ctsa_pkg::*;

  logic [WIDTH-1:0] below;

  // Each bit survives only if no lower bit is set
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      if (g == 0) begin : g_first
        assign below[g] = 1'b0;
      end else begin : g_rest
        assign below[g] = below[g-1] | vec[g-1];
      end
      assign onehot[g] = vec[g] & ~below[g];
    end
  endgenerate

  // Binary index of the surviving bit
  always_comb begin
    index = 2'h0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (onehot[i]) begin
        index = i[1:0];
      end
    end
  end

  assign any = |vec;

endmodule // ctsa_lowest_bit

// File: logic/ctsa_regs.sv
// Transmit buffer empty, abort request and acknowledge, buffer select,
// acceptance control and reserved registers behind an Avalon-MM slave.
// Assumes the protocol engine runs on ref_clk and gives one-cycle event pulses.
`include "ctsa_defines.svh"
module ctsa_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Mode handshake from the controller core
  input wire logic init_request,
  input wire logic init_acknowledge,
  input wire logic listen_mode,
  // Protocol engine
  input wire ctsa_pkg::ctsa_engine_t engine,
  output logic [2:0] tx_scheduled,
  output logic [2:0] abort_pending,
  output ctsa_pkg::ctsa_mode_t acceptance_mode,
  output logic filter_closed,
  // Shared transmit window
  input wire ctsa_pkg::ctsa_win_req_t win_req,
  output ctsa_pkg::ctsa_win_ans_t win_ans,
  // Interrupt
  output logic irq
);
  import ctsa_pkg::*;

  typedef struct packed {
    logic [2:0] buffer_empty_flag;
    logic [2:0] abort_request_flag;
    logic [2:0] abort_ack_flag;
    logic [2:0] select;
    logic [1:0] mode;
    logic [2:0] hit;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    ctsa_win_ans_t win;
  } ctsa_state_t;

  ctsa_state_t st;
  ctsa_state_t next_st;

  logic init_mode;
  logic run_mode;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic [2:0] sel_onehot;
  logic [1:0] sel_index;
  logic sel_any;
  logic [2:0] grant_abort;
  logic [2:0] done_set;

  assign init_mode = init_request & init_acknowledge;
  assign run_mode = ~init_request & ~init_acknowledge;
  assign wr_acc = avs_write & ~st.ack;
  assign rd_acc = avs_read & ~st.ack;
  assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : `CTSA_RST_ZERO8;

  // Lowest set select bit picks the mapped buffer
  ctsa_lowest_bit #(
    .WIDTH(`CTSA_NBUF)
  ) u_sel (
    .vec(st.select),
    .onehot(sel_onehot),
    .index(sel_index),
    .any(sel_any)
  );

  // Abort granted before start, or after a failed attempt
  assign grant_abort = engine.abort_slot & st.abort_request_flag & ~st.buffer_empty_flag
    & (~engine.tx_started | engine.tx_failed);
  assign done_set = engine.sent_ok | grant_abort;

  // Next state: bus access, engine events, init hold
  always_comb begin
    next_st = st;
    next_st.ack = (avs_read | avs_write) & ~st.ack;
    next_st.resp = 2'h0;
    next_st.rdata = `CTSA_RST_ZERO32;
    next_st.win = '0;

    // Engine events
    next_st.buffer_empty_flag = st.buffer_empty_flag | done_set;
    next_st.abort_ack_flag = st.abort_ack_flag | grant_abort;
    next_st.abort_request_flag = st.abort_request_flag & ~done_set;
    if (engine.rx_shift && st.mode != CTSA_CLOSED) begin
      next_st.hit = engine.rx_hit;
    end

    // Register writes
    if (wr_acc) begin
      case (avs_address)
        `CTSA_OFS_EMPTY: begin
          // Writing 1 clears an empty flag, scheduling the buffer
          if (!listen_mode) begin
            // Keep a same-cycle completion: the engine's set wins over the clear
            next_st.buffer_empty_flag = next_st.buffer_empty_flag & ~(wbyte[2:0] & ~done_set);
            next_st.abort_ack_flag = next_st.abort_ack_flag & ~(wbyte[2:0] & ~grant_abort);
          end
        end
        `CTSA_OFS_ABORT_RQ: begin
          if (run_mode) begin
            next_st.abort_request_flag = next_st.abort_request_flag | (wbyte[2:0] & ~next_st.buffer_empty_flag);
          end
        end
        `CTSA_OFS_ABORT_AK: begin
          next_st.abort_ack_flag = next_st.abort_ack_flag;
        end
        `CTSA_OFS_SELECT: begin
          if (run_mode) begin
            next_st.select = wbyte[2:0];
          end
        end
        `CTSA_OFS_ACC_CTL: begin
          if (init_mode) begin
            next_st.mode = wbyte[`CTSA_MODE_HI:`CTSA_MODE_LO];
          end
        end
        `CTSA_OFS_RESERVED: begin
          next_st.resp = 2'h0;
        end
        `CTSA_OFS_IRQ_STAT: begin
          next_st.resp = 2'h0;
        end
        `CTSA_OFS_IRQ_MASK: begin
          next_st.irq_mask = wbyte[2:0];
        end
        default: begin
          next_st.resp = 2'h2;
        end
      endcase
    end

    // Register reads
    if (rd_acc) begin
      case (avs_address)
        `CTSA_OFS_EMPTY: next_st.rdata[2:0] = st.buffer_empty_flag;
        `CTSA_OFS_ABORT_RQ: next_st.rdata[2:0] = st.abort_request_flag;
        `CTSA_OFS_ABORT_AK: next_st.rdata[2:0] = st.abort_ack_flag;
        `CTSA_OFS_SELECT: next_st.rdata[2:0] = sel_onehot;
        `CTSA_OFS_ACC_CTL: begin
          next_st.rdata[`CTSA_MODE_HI:`CTSA_MODE_LO] = st.mode;
          next_st.rdata[`CTSA_HIT_HI:`CTSA_HIT_LO] = st.hit;
        end
        `CTSA_OFS_RESERVED: next_st.rdata = `CTSA_RST_ZERO32;
        `CTSA_OFS_IRQ_STAT: next_st.rdata[2:0] = st.irq_stat;
        `CTSA_OFS_IRQ_MASK: next_st.rdata[2:0] = st.irq_mask;
        default: next_st.resp = 2'h2;
      endcase
    end

    // Sticky status: set wins over the read clear
    if (rd_acc && avs_address == `CTSA_OFS_IRQ_STAT) begin
      next_st.irq_stat = `CTSA_RST_ZERO3;
    end
    if (|grant_abort) begin
      next_st.irq_stat[`CTSA_IRQ_ABORT] = 1'b1;
    end
    if (|engine.sent_ok) begin
      next_st.irq_stat[`CTSA_IRQ_SENT] = 1'b1;
    end
    if (engine.rx_shift && st.mode != CTSA_CLOSED) begin
      next_st.irq_stat[`CTSA_IRQ_RXHIT] = 1'b1;
    end

    // Shared window: only the selected, unscheduled buffer is reachable
    if (win_req.req) begin
      if (sel_any && st.buffer_empty_flag[sel_index]) begin
        next_st.win.grant = 1'b1;
        next_st.win.buffer = sel_index;
      end else begin
        next_st.win.denied = 1'b1;
      end
    end

    // Init mode holds these registers at reset
    if (init_mode) begin
      next_st.abort_ack_flag = `CTSA_RST_ZERO3;
      next_st.abort_request_flag = `CTSA_RST_ZERO3;
      next_st.select = `CTSA_RST_ZERO3;
      next_st.buffer_empty_flag = `CTSA_RST_EMPTY;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.buffer_empty_flag <= `CTSA_RST_EMPTY;
      st.mode <= `CTSA_RST_MODE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
  assign avs_readdata = st.rdata;
  assign avs_response = st.resp;
  assign tx_scheduled = ~st.buffer_empty_flag;
  assign abort_pending = st.abort_request_flag;
  assign acceptance_mode = ctsa_mode_t'(st.mode);
  assign filter_closed = (st.mode == CTSA_CLOSED);
  assign win_ans = st.win;
  assign irq = |(st.irq_stat & st.irq_mask);

endmodule // ctsa_regs

// File: tb/ctsa_regs_props.sv
// Concurrent checks on the ports of the transmit select and acceptance register block.
// Assumes it is bound to ctsa_regs and runs on its single clock domain.
module ctsa_regs_props (
  // Clock, reset and bus
  input logic ref_clk,
  input logic rst,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  // Core and engine side
  input logic init_request,
  input logic init_acknowledge,
  input ctsa_pkg::ctsa_engine_t engine,
  input logic [2:0] tx_scheduled,
  input logic [2:0] abort_pending,
  input ctsa_pkg::ctsa_mode_t acceptance_mode,
  input logic filter_closed,
  input ctsa_pkg::ctsa_win_req_t win_req,
  input ctsa_pkg::ctsa_win_ans_t win_ans
);
  timeunit 1ns;
  timeprecision 1ns;
  import ctsa_pkg::*;
  logic rd_ok;
  logic in_init;
  // Accepted read and init mode helpers
  assign rd_ok = avs_read && !avs_waitrequest;
  assign in_init = init_request && init_acknowledge;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ack_init_a:
    assert property (rd_ok && avs_address == 4'h2 && $past(in_init) && $past(in_init, 2) |-> avs_readdata == 32'h0)
    else $error("abort ack not held in init");
  sel_lowest_a:
    assert property (rd_ok && avs_address == 4'h3 |-> $onehot0(avs_readdata)) else $error("select read not one-hot");
  rsvd_zero_a:
    assert property (rd_ok && avs_address == 4'h5 |-> avs_readdata == 32'h0) else $error("reserved read not zero");
  closed_flag_a:
    assert property (acceptance_mode == CTSA_CLOSED && $past(acceptance_mode) == CTSA_CLOSED |-> filter_closed)
    else $error("closed flag missing");
  win_busy_a:
    assert property (win_req.req && tx_scheduled == 3'h7 |=> win_ans.denied && !win_ans.grant)
    else $error("window not blocked");
  win_answer_a:
    assert property (win_req.req |=> win_ans.grant ^ win_ans.denied) else $error("window answer missing");
  abort_grant_a:
    assert property (engine.abort_slot[1] && abort_pending[1] && tx_scheduled[1] && !engine.tx_started[1]
      |=> !tx_scheduled[1] && !abort_pending[1]) else $error("abort not granted");
  acc_locked_a:
    assert property ($changed(acceptance_mode) |-> $past(in_init) || $past(in_init, 2))
    else $error("mode changed outside init");
endmodule // ctsa_regs_props

// File: tb/ctsa_engine_model.sv
// Behavioural protocol engine: replays one event word for one cycle on command.
// Assumes the bench raises go for one cycle just after a rising edge.
module ctsa_engine_model (
  // Clock
  input logic ref_clk,
  // Bench command
  input logic go,
  input ctsa_pkg::ctsa_engine_t ev,
  // Engine events
  output ctsa_pkg::ctsa_engine_t engine
);
  timeunit 1ns;
  timeprecision 1ns;
  import ctsa_pkg::*;
  // Events are one-cycle pulses, quiet otherwise
  always @(posedge ref_clk) begin
    engine <= go ? ev : '0;
  end
endmodule // ctsa_engine_model

// File: tb/ctsa_regs_tb.sv
// Self-checking bench for the transmit select and acceptance register block.
// Assumes ctsa_pkg, the engine model and the checker are compiled first.
module ctsa_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ctsa_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic init_request = 1'b0;
  logic init_acknowledge = 1'b0;
  logic go = 1'b0;
  ctsa_engine_t ev = '0;
  ctsa_engine_t engine;
  logic [2:0] tx_scheduled;
  logic [2:0] abort_pending;
  ctsa_mode_t acceptance_mode;
  logic filter_closed;
  ctsa_win_req_t win_req = '0;
  ctsa_win_ans_t win_ans;
  logic irq;
  logic [31:0] q;
  logic [1:0] rsp;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  ctsa_regs i_dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest, .avs_response, .init_request, .init_acknowledge, .listen_mode(1'b0),
    .engine, .tx_scheduled, .abort_pending, .acceptance_mode, .filter_closed, .win_req, .win_ans, .irq);
  ctsa_engine_model i_eng (.ref_clk, .go, .ev, .engine);
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    // Waitrequest seen low ends this wait, or else the bench's hang guard
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // Engine event word, one cycle long
  task automatic ping(input ctsa_engine_t e);
    ev <= e;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // Window request; answer lands one cycle later
  task automatic win(input logic g, input logic [1:0] b);
    win_req.req <= 1'b1;
    @(posedge ref_clk);
    win_req.req <= 1'b0;
    @(posedge ref_clk);
    chk({win_ans.grant, win_ans.denied, g ? win_ans.buffer : 2'h0}, {g, !g, b});
  endtask
  task automatic mode(input logic on);
    init_request <= on;
    init_acknowledge <= on;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_reset();
    rd(4'h0, 8'h07);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    bus(1'b0, 4'h9, 8'h00);
    chk(rsp, 2'b10);
  endtask
  task automatic t_select();
    wr(4'h3, 8'h06);
    rd(4'h3, 8'h02);
    win(1'b1, 2'h1);
    wr(4'h3, 8'h00);
    win(1'b0, 2'h0);
    bus(1'b0, 4'h0, 8'h00);
    wr(4'h3, q[7:0]);
    rd(4'h3, 8'h01);
  endtask
  // Abort granted, refused while sending, granted after failure
  task automatic t_abort();
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h07);
    wr(4'h3, 8'h02);
    win(1'b0, 2'h0);
    wr(4'h1, 8'h02);
    ping(16'h0020);
    rd(4'h0, 8'h02);
    rd(4'h2, 8'h02);
    chk(irq, 1'b1);
    rd(4'h6, 8'h01);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h02);
    wr(4'h0, 8'h02);
    rd(4'h2, 8'h00);
    wr(4'h1, 8'h02);
    ping(16'h0820);
    rd(4'h1, 8'h02);
    ping(16'h0920);
    rd(4'h0, 8'h02);
  endtask
  task automatic t_accept();
    mode(1'b1);
    rd(4'h2, 8'h00);
    wr(4'h3, 8'h01);
    rd(4'h3, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(4'h4, {2'h0, m[1:0], 4'h7});
      rd(4'h4, {2'h0, m[1:0], 4'h0});
      chk(acceptance_mode, m[1:0]);
    end
    wr(4'h4, 8'h10);
    mode(1'b0);
    wr(4'h4, 8'h30);
    rd(4'h4, 8'h10);
    ping(16'h000D);
    rd(4'h4, 8'h15);
    mode(1'b1);
    wr(4'h4, 8'h30);
    mode(1'b0);
    chk(filter_closed, 1'b1);
    ping(16'h000A);
    rd(4'h4, 8'h35);
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_select();
    t_abort();
    t_accept();
    conclude();
  end
endmodule // ctsa_regs_tb
bind ctsa_regs ctsa_regs_props i_props (.ref_clk, .rst, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .init_request, .init_acknowledge, .engine, .tx_scheduled, .abort_pending, .acceptance_mode, .filter_closed,
  .win_req, .win_ans);
